// [include/lcm_pkg.sv]
/*
  Constants, field positions and carrier types for the local connection
  memory block: entry layouts, processor address split and fetch timing.
  Assumes nothing beyond a SystemVerilog compiler that accepts packages.
*/
package lcm_pkg;

  // Memory geometry
  localparam int unsigned ENTRY_COUNT    = 4096;  // Entries, one per stream and channel
  localparam int unsigned ENTRY_WIDTH    = 16;    // Bits per entry
  localparam int unsigned INDEX_WIDTH    = 12;    // log2 of ENTRY_COUNT

  // Processor address split
  localparam int unsigned ADDR_WIDTH     = 15;    // A14..A0
  localparam int unsigned ADDR_MEM_BIT   = 14;    // Memory space select
  localparam int unsigned ADDR_STREAM_HI = 13;    // Stream field top
  localparam int unsigned ADDR_STREAM_LO = 9;     // Stream field bottom
  localparam int unsigned ADDR_CHAN_HI   = 8;     // Channel field top
  localparam int unsigned ADDR_CHAN_LO   = 0;     // Channel field bottom

  // Memory select code that points at this memory
  localparam logic [2:0]  MEM_SEL_LOCAL_CONN = 3'h0;

  // Entry field positions, both layouts
  localparam int unsigned BIT_SOURCE_SEL  = 15;   // 0 backplane, 1 local
  localparam int unsigned BIT_MESSAGE     = 14;   // 1 constant message byte
  localparam int unsigned BIT_OUT_ENABLE  = 13;   // 1 drive the channel
  localparam int unsigned STD_STREAM_HI   = 12;   // Standard layout stream field
  localparam int unsigned STD_STREAM_LO   = 8;
  localparam int unsigned STD_CHAN_HI     = 7;    // Standard layout channel field
  localparam int unsigned FAST_STREAM_HI  = 12;   // Fast layout stream field
  localparam int unsigned FAST_STREAM_LO  = 9;
  localparam int unsigned FAST_CHAN_HI    = 8;    // Fast layout channel field
  localparam int unsigned MSG_HI          = 7;    // Message byte
  localparam int unsigned MSG_MSB         = 7;    // First bit shifted out

  // Fifo and reset values
  localparam int unsigned FIFO_DEPTH      = 4;
  localparam logic [15:0] RDATA_RESET     = 16'h0000;
  localparam logic [2:0]  BIT_LAST        = 3'h7; // Eighth bit of a slot

  // Timeslot request from the output stream timing
  typedef struct packed {
    logic [3:0] stream;   // Local output stream 0..15
    logic [8:0] channel;  // Channel within the stream
    logic       fast;     // Connection runs at 32 Mbps
  } slot_req_s;

  // Byte ready for one output timeslot
  typedef struct packed {
    logic [3:0] stream;   // Destination stream
    logic       enable;   // Drive the timeslot
    logic [7:0] data;     // Byte to shift out
  } slot_byte_s;

  // Source data memory read request
  typedef struct packed {
    logic       local_src; // 1 local, 0 backplane
    logic [4:0] stream;    // Source stream
    logic [8:0] channel;   // Source channel
  } src_req_s;

endpackage : lcm_pkg

// [hdl/lcm_store.sv]
/*
  Entry store of the local connection memory and the slot byte fifo.
  Assumes one synchronous clock and an active high synchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none

// Single port store, registered read data
module lcm_store #(
  parameter int unsigned DEPTH = 4096,
  parameter int unsigned WIDTH = 16,
  parameter int unsigned AW    = 12
) (
  // Clock
  input  wire logic             clk_sys_i,
  // Access port
  input  wire logic             en_i,
  input  wire logic             wr_i,
  input  wire logic [AW-1:0]    index_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  output logic      [WIDTH-1:0] rdata_o
);
  // Elaboration check: index width must cover the depth exactly
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("lcm_store: DEPTH must equal 2**AW");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Entry array

  // Write or read one entry
  always_ff @(posedge clk_sys_i) begin
    if (en_i && wr_i) begin
      mem[index_i] <= wdata_i;
    end else if (en_i) begin
      rdata_o <= mem[index_i];
    end
  end
endmodule : lcm_store

// Small fifo with valid and ready on both sides
module lcm_fifo #(
  parameter int unsigned WIDTH = 13,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // Elaboration check: pointers wrap only for a power of two depth
  if (DEPTH < 2 || DEPTH != (1 << PW)) begin : g_bad_depth
    $error("lcm_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] buf_q [DEPTH];  // Storage
  logic [PW-1:0]    wr_q;           // Write pointer
  logic [PW-1:0]    rd_q;           // Read pointer
  logic [PW:0]      cnt_q;          // Occupancy
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q < (PW+1)'(DEPTH));  // Room for one more word
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = buf_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage write
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      buf_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : lcm_fifo

`default_nettype wire

// [hdl/local_connection_memory.sv]
/*
  Local connection memory: processor access to the per channel connection
  entries, and a fetch engine that turns each local output timeslot into a
  byte (switched or message) shifted out most significant bit first.
  Assumes the output timing logic asks for each slot ahead of its first bit
  and gives one bit_tick_i per bit, and that the data memories answer a
  source request with one src_data_valid_i pulse.
*/
// Overview of operation
// - 4096 sixteen-bit entries, one per stream/channel
// - Address: stream A13-A9, channel A8-A0
// - Two entry layouts chosen by 32 Mbps connection
// - Bit 15 picks backplane or local data
// - Bit 14 sends entry low byte as message
// - Message mode ignores source select and stream
// - Message byte shifted out MSB first
// - Bit 13 drives channel, else high impedance
// - Standard: stream bits 12:8, channel 7:0
// - Fast: stream bits 12:9, channel 8:0
// - Entries govern local output streams 0-15
`timescale 1ns/1ns
`default_nettype none

module local_connection_memory #(
  parameter int unsigned FIFO_DEPTH = lcm_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_i,
  // Processor port
  input  wire logic                 cpu_sel_i,
  input  wire logic                 cpu_wr_i,
  input  wire logic [14:0]          cpu_addr_i,
  input  wire logic [15:0]          cpu_wdata_i,
  input  wire logic [2:0]           memory_select_field_i,
  output logic      [15:0]          cpu_rdata_o,
  output logic                      cpu_rvalid_o,
  // Port wide rate
  input  wire logic                 local_fast_i,
  // Timeslot requests
  input  wire logic                 slot_valid_i,
  input  wire lcm_pkg::slot_req_s   slot_req_i,
  output logic                      slot_ready_o,
  // Source data memory access
  output logic                      src_req_valid_o,
  output lcm_pkg::src_req_s         src_req_o,
  input  wire logic                 src_data_valid_i,
  input  wire logic [7:0]           src_data_i,
  // Local serial output
  input  wire logic                 bit_tick_i,
  input  wire logic                 local_output_resolve_pin_i,
  output logic                      local_serial_outputs_o,
  output logic                      local_serial_oe_o,
  output logic                      local_ext_hiz_o,
  output logic      [3:0]           local_serial_stream_o
);
  // Elaboration check: the byte fifo needs at least two words
  if (FIFO_DEPTH < 2) begin : g_bad_fifo_depth
    $error("local_connection_memory: FIFO_DEPTH too small");
  end

  typedef enum logic [2:0] {F_IDLE, F_READ, F_DECODE, F_SOURCE, F_PUSH} fetch_e;

  // Index of an entry from stream and channel
  function automatic logic [11:0] entry_index(input logic [4:0] stream, input logic [8:0] chan,
                                              input logic fast);
    entry_index = fast ? {stream[2:0], chan} : {stream[3:0], chan[7:0]};
  endfunction : entry_index

  fetch_e               fetch_q;        // Fetch engine state
  lcm_pkg::slot_req_s   req_q;          // Slot being prepared
  lcm_pkg::slot_byte_s  byte_q;         // Byte waiting for the fifo
  logic                 cpu_hit;        // Processor addresses this memory
  logic                 mem_en;         // Store port enable
  logic                 mem_wr;         // Store write
  logic [11:0]          mem_index;      // Store index
  logic [15:0]          mem_rdata;      // Store read data
  logic                 cpu_rd_q;       // Processor read in flight
  logic                 fifo_in_ready;  // Fifo can take a byte
  logic                 fifo_out_valid; // Fifo holds a byte
  lcm_pkg::slot_byte_s  fifo_out;       // Byte at the fifo head
  logic                 ser_busy_q;     // Shifter owns a slot
  logic [2:0]           bit_cnt_q;      // Bit within the slot
  logic [7:0]           shift_q;        // Bits left to send

  // Processor owns the port when it targets this memory
  assign cpu_hit   = cpu_sel_i && cpu_addr_i[lcm_pkg::ADDR_MEM_BIT]
                     && (memory_select_field_i == lcm_pkg::MEM_SEL_LOCAL_CONN);
  assign mem_en    = cpu_hit || (fetch_q == F_READ);
  assign mem_wr    = cpu_hit && cpu_wr_i;
  // Processor address or the slot being fetched
  assign mem_index = cpu_hit
    ? entry_index(cpu_addr_i[lcm_pkg::ADDR_STREAM_HI:lcm_pkg::ADDR_STREAM_LO],
                  cpu_addr_i[lcm_pkg::ADDR_CHAN_HI:lcm_pkg::ADDR_CHAN_LO], local_fast_i)
    : entry_index({1'b0, req_q.stream}, req_q.channel, local_fast_i);

  // Entry array
  lcm_store #(
    .DEPTH (lcm_pkg::ENTRY_COUNT),
    .WIDTH (lcm_pkg::ENTRY_WIDTH),
    .AW    (lcm_pkg::INDEX_WIDTH)
  ) u_store (
    .clk_sys_i (clk_sys_i),
    .en_i      (mem_en),
    .wr_i      (mem_wr),
    .index_i   (mem_index),
    .wdata_i   (cpu_wdata_i),
    .rdata_o   (mem_rdata)
  );

  // Processor read answer, two cycles after the request
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cpu_rd_q     <= 1'b0;
      cpu_rvalid_o <= 1'b0;
      cpu_rdata_o  <= lcm_pkg::RDATA_RESET;
    end else begin
      cpu_rd_q     <= cpu_hit && !cpu_wr_i;
      cpu_rvalid_o <= cpu_rd_q;
      if (cpu_rd_q) begin
        cpu_rdata_o <= mem_rdata;
      end
    end
  end

  // Fetch engine: entry read, decode, source read, push
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fetch_q         <= F_IDLE;
      req_q           <= '0;
      byte_q          <= '0;
      slot_ready_o    <= 1'b1;
      src_req_valid_o <= 1'b0;
      src_req_o       <= '0;
    end else begin
      src_req_valid_o <= 1'b0;
      unique case (fetch_q)
        // Take the next timeslot ahead of time
        F_IDLE: begin
          if (slot_valid_i) begin
            req_q        <= slot_req_i;
            slot_ready_o <= 1'b0;
            fetch_q      <= F_READ;
          end
        end
        // Read waits while the processor holds the port
        F_READ: begin
          if (!cpu_hit) begin
            fetch_q <= F_DECODE;
          end
        end
        // Interpret the entry
        F_DECODE: begin
          byte_q.stream <= req_q.stream;
          byte_q.enable <= mem_rdata[lcm_pkg::BIT_OUT_ENABLE];
          if (mem_rdata[lcm_pkg::BIT_MESSAGE]) begin
            // Constant byte, source fields disregarded
            byte_q.data <= mem_rdata[lcm_pkg::MSG_HI:0];
            fetch_q     <= F_PUSH;
          end else begin
            src_req_valid_o     <= 1'b1;
            src_req_o.local_src <= mem_rdata[lcm_pkg::BIT_SOURCE_SEL];
            if (req_q.fast) begin
              src_req_o.stream  <= {1'b0, mem_rdata[lcm_pkg::FAST_STREAM_HI:lcm_pkg::FAST_STREAM_LO]};
              src_req_o.channel <= mem_rdata[lcm_pkg::FAST_CHAN_HI:0];
            end else begin
              src_req_o.stream  <= mem_rdata[lcm_pkg::STD_STREAM_HI:lcm_pkg::STD_STREAM_LO];
              src_req_o.channel <= {1'b0, mem_rdata[lcm_pkg::STD_CHAN_HI:0]};
            end
            fetch_q <= F_SOURCE;
          end
        end
        // Wait for the data memory byte
        F_SOURCE: begin
          if (src_data_valid_i) begin
            byte_q.data <= src_data_i;
            fetch_q     <= F_PUSH;
          end
        end
        // Hand the byte to the fifo, stall while full
        F_PUSH: begin
          if (fifo_in_ready) begin
            slot_ready_o <= 1'b1;
            fetch_q      <= F_IDLE;
          end
        end
      endcase
    end
  end

  // Prepared bytes wait here for their timeslot
  lcm_fifo #(
    .WIDTH ($bits(lcm_pkg::slot_byte_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .in_valid_i  (fetch_q == F_PUSH),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (byte_q),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!ser_busy_q),
    .out_data_o  (fifo_out)
  );

  // Shift each slot byte out, first bit is bit 7
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ser_busy_q             <= 1'b0;
      bit_cnt_q              <= '0;
      shift_q                <= '0;
      local_serial_outputs_o <= 1'b0;
      local_serial_oe_o      <= 1'b0;
      local_ext_hiz_o        <= 1'b1;
      local_serial_stream_o  <= '0;
    end else begin
      if (!ser_busy_q && fifo_out_valid) begin
        ser_busy_q             <= 1'b1;
        bit_cnt_q              <= '0;
        shift_q                <= fifo_out.data;
        local_serial_outputs_o <= fifo_out.data[lcm_pkg::MSG_MSB];
        local_serial_stream_o  <= fifo_out.stream;
        // Pin goes high impedance unless an external buffer does it
        local_serial_oe_o      <= fifo_out.enable || local_output_resolve_pin_i;
        local_ext_hiz_o        <= !fifo_out.enable;
      end else if (ser_busy_q && bit_tick_i) begin
        if (bit_cnt_q == lcm_pkg::BIT_LAST) begin
          ser_busy_q <= 1'b0;
        end else begin
          bit_cnt_q              <= bit_cnt_q + 3'h1;
          shift_q                <= {shift_q[6:0], 1'b0};
          local_serial_outputs_o <= shift_q[6];
        end
      end
    end
  end

endmodule : local_connection_memory

`default_nettype wire

// [testbench/lcm_checker_properties.sv]
/*
  Port checker for the local connection memory: processor answers, refusals
  and the timeslot fetch handshake.
  Assumes it is bound onto local_connection_memory and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none

module lcm_checker (
  // Clock and reset
  input wire logic              clk_sys_i,
  input wire logic              reset_i,
  // Processor port
  input wire logic              cpu_sel_i,
  input wire logic              cpu_wr_i,
  input wire logic [14:0]       cpu_addr_i,
  input wire logic [2:0]        memory_select_field_i,
  input wire logic [15:0]       cpu_rdata_o,
  input wire logic              cpu_rvalid_o,
  // Slot fetch
  input wire logic              slot_valid_i,
  input wire logic              slot_ready_o,
  input wire logic              src_req_valid_o,
  input wire lcm_pkg::src_req_s src_req_o
);
  // Read access taken this cycle
  logic take_rd;
  assign take_rd = cpu_sel_i & ~cpu_wr_i & cpu_addr_i[14] & (memory_select_field_i == 3'h0);

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  property p_read_answer; take_rd |-> ##2 cpu_rvalid_o; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer missing");
  property p_no_mem_bit; cpu_sel_i && !cpu_addr_i[14] |-> ##2 !cpu_rvalid_o; endproperty
  a_no_mem_bit: assert property (p_no_mem_bit) else $error("register space answered");
  property p_wrong_sel; cpu_sel_i && memory_select_field_i != 3'h0 |-> ##2 !cpu_rvalid_o; endproperty
  a_wrong_sel: assert property (p_wrong_sel) else $error("other memory answered");
  property p_rvalid_cause; cpu_rvalid_o |-> $past(take_rd, 2); endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without read");
  property p_rdata_held; !cpu_rvalid_o |-> $stable(cpu_rdata_o); endproperty
  a_rdata_held: assert property (p_rdata_held) else $error("read data moved");
  property p_ready_drop; slot_valid_i && slot_ready_o |=> !slot_ready_o; endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("slot not held");
  property p_src_pulse; src_req_valid_o |=> !src_req_valid_o; endproperty
  a_src_pulse: assert property (p_src_pulse) else $error("source request too long");
  property p_src_in_slot; src_req_valid_o |-> !slot_ready_o; endproperty
  a_src_in_slot: assert property (p_src_in_slot) else $error("source request while idle");
endmodule : lcm_checker

bind local_connection_memory lcm_checker u_chk (.clk_sys_i, .reset_i, .cpu_sel_i, .cpu_wr_i, .cpu_addr_i,
  .memory_select_field_i, .cpu_rdata_o, .cpu_rvalid_o, .slot_valid_i, .slot_ready_o, .src_req_valid_o,
  .src_req_o);

`default_nettype wire

// [testbench/src_memory_model.sv]
/*
  Data memory model answering source byte requests, promptly or slowly.
  Assumes one request at a time, as the fetch engine issues them.
*/
`timescale 1ns/1ns
`default_nettype none

module src_memory_model (
  // Clock, reset and pace
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  input  wire logic              slow_i,
  // Request and answer
  input  wire logic              req_valid_i,
  input  wire lcm_pkg::src_req_s req_i,
  output logic                   data_valid_o,
  output logic [7:0]             data_o,
  output int                     req_count_o
);
  logic [3:0] wait_q;  // Cycles left before the answer
  logic [7:0] byte_q;  // Byte of the pending answer

  // Answer one cycle later, or six when slow; stale data toggles
  always_ff @(posedge clk_sys_i) begin
    data_valid_o <= 1'b0;
    data_o       <= ~data_o;
    if (reset_i) begin
      wait_q      <= 4'h0;
      data_o      <= 8'h00;
      req_count_o <= 0;
    end else if (req_valid_i) begin
      wait_q      <= slow_i ? 4'h6 : 4'h1;
      byte_q      <= {req_i.local_src, req_i.stream[2:0], req_i.channel[3:0]};
      req_count_o <= req_count_o + 1;
    end else if (wait_q == 4'h1) begin
      wait_q       <= 4'h0;
      data_valid_o <= 1'b1;
      data_o       <= byte_q;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule : src_memory_model

`default_nettype wire

// [testbench/tb_local_connection_memory.sv]
/*
  Bench for the local connection memory: processor accesses, slot runs and
  a fifo fill. Assumes the package, design, checker and source model.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t %s", $time, m); end end

module tb_local_connection_memory;
  // Design ports and bench state
  logic clk_sys_i, reset_i, cpu_sel_i, cpu_wr_i, cpu_rvalid_o, local_fast_i, slot_valid_i, slot_ready_o, slow;
  logic src_req_valid_o, src_data_valid_i, bit_tick_i, local_output_resolve_pin_i;
  logic local_serial_outputs_o, local_serial_oe_o, local_ext_hiz_o;
  logic [14:0] cpu_addr_i;
  logic [15:0] cpu_wdata_i, cpu_rdata_o;
  logic [2:0]  memory_select_field_i;
  logic [7:0]  src_data_i;
  logic [3:0]  local_serial_stream_o;
  lcm_pkg::slot_req_s slot_req_i;
  lcm_pkg::src_req_s  src_req_o;
  int fail_count, n_compared, req_count;
  // Slot table: entry, stream, channel, layout
  logic [15:0] ent [4] = '{16'hfea5, 16'h33c4, 16'hb7c4, 16'h4081};
  logic [3:0]  sst [4] = '{4'h1, 4'h2, 4'hf, 4'h7};
  logic [7:0]  sch [4] = '{8'h03, 8'h10, 8'hff, 8'h20};
  logic        sfa [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

  local_connection_memory dut (.clk_sys_i, .reset_i, .cpu_sel_i, .cpu_wr_i, .cpu_addr_i, .cpu_wdata_i,
    .memory_select_field_i, .cpu_rdata_o, .cpu_rvalid_o, .local_fast_i, .slot_valid_i, .slot_req_i,
    .slot_ready_o, .src_req_valid_o, .src_req_o, .src_data_valid_i, .src_data_i, .bit_tick_i,
    .local_output_resolve_pin_i, .local_serial_outputs_o, .local_serial_oe_o, .local_ext_hiz_o,
    .local_serial_stream_o);
  src_memory_model partner (.clk_sys_i, .reset_i, .slow_i(slow), .req_valid_i(src_req_valid_o),
    .req_i(src_req_o), .data_valid_o(src_data_valid_i), .data_o(src_data_i), .req_count_o(req_count));

  // 25 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Counts and verdict, then end of run
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // One processor write strobe
  task automatic cpu_write(input logic [14:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    cpu_sel_i   <= 1'b1;
    cpu_wr_i    <= 1'b1;
    cpu_addr_i  <= a;
    cpu_wdata_i <= d;
    @(posedge clk_sys_i);
    cpu_sel_i   <= 1'b0;
  endtask : cpu_write

  // One processor read; ans says whether an answer is due
  task automatic cpu_read(input logic [14:0] a, input logic [15:0] e, input logic ans);
    logic got;
    got = 1'b0;
    @(posedge clk_sys_i);
    cpu_sel_i  <= 1'b1;
    cpu_wr_i   <= 1'b0;
    cpu_addr_i <= a;
    @(posedge clk_sys_i);
    cpu_sel_i  <= 1'b0;
    repeat (3) begin
      @(negedge clk_sys_i);
      if (cpu_rvalid_o === 1'b1) got = 1'b1;
    end
    `CHK(got, ans, "read answer")
    if (ans) `CHK(cpu_rdata_o, e, "read data")
  endtask : cpu_read

  // Bounded wait for an idle fetch engine
  task automatic wait_ready;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys_i);
      if (slot_ready_o === 1'b1) break;
    end
    if (slot_ready_o !== 1'b1) begin
      fail_count++;
      $display("MISMATCH t=%0t slot wait ran out", $time);
      stop_test();
    end
  endtask : wait_ready

  // Offer one timeslot request
  task automatic send_slot(input logic [3:0] st, input logic [8:0] ch, input logic f);
    wait_ready();
    @(posedge clk_sys_i);
    slot_valid_i <= 1'b1;
    slot_req_i   <= '{stream: st, channel: ch, fast: f};
    @(posedge clk_sys_i);
    slot_valid_i <= 1'b0;
  endtask : send_slot

  // Shift one byte out with eight ticks, checking every bit of an enabled byte
  task automatic drain(input logic [3:0] st, input logic [7:0] b, input logic en);
    @(posedge clk_sys_i);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk_sys_i);
      `CHK(local_serial_oe_o, en | local_output_resolve_pin_i, "output enable")
      `CHK(local_serial_stream_o, st, "output stream")
      if (en) `CHK(local_serial_outputs_o, b[i], "serial bit")
      if (local_output_resolve_pin_i) `CHK(local_ext_hiz_o, ~en, "external buffer")
      @(posedge clk_sys_i);
      bit_tick_i <= 1'b1;
      @(posedge clk_sys_i);
      bit_tick_i <= 1'b0;
    end
  endtask : drain

  // Main sequence
  initial begin
    int j;
    logic [7:0] b;
    lcm_pkg::src_req_s r;
    {fail_count, n_compared} = '0;
    {reset_i, cpu_sel_i, cpu_wr_i, local_fast_i, slot_valid_i, bit_tick_i} = 6'h20;
    {local_output_resolve_pin_i, slow, memory_select_field_i, cpu_addr_i, cpu_wdata_i} = '0;
    slot_req_i = '0;
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      cpu_write({2'b10, sst[k], 1'b0, sch[k]}, ent[k]);
      cpu_read({2'b10, sst[k], 1'b0, sch[k]}, ent[k], 1'b1);
    end
    cpu_write({2'b00, 4'h1, 9'h003}, 16'h0000);
    cpu_read({2'b00, 4'h1, 9'h003}, 16'h0000, 1'b0);
    @(posedge clk_sys_i) memory_select_field_i <= 3'h2;
    cpu_write({2'b10, 4'h1, 9'h003}, 16'h0000);
    cpu_read({2'b10, 4'h1, 9'h003}, 16'h0000, 1'b0);
    @(posedge clk_sys_i) memory_select_field_i <= 3'h0;
    cpu_read({2'b10, 4'h1, 9'h003}, 16'hfea5, 1'b1);
    @(posedge clk_sys_i) local_fast_i <= 1'b1;
    cpu_write({2'b10, 4'h3, 9'h1ab}, 16'h1234);
    cpu_read({2'b10, 4'h3, 9'h1ab}, 16'h1234, 1'b1);
    @(posedge clk_sys_i) local_fast_i <= 1'b0;
    // Same entry seen through the standard address packing
    cpu_read({2'b10, 4'h7, 1'b0, 8'hab}, 16'h1234, 1'b1);
    // Message, backplane, slow local fast layout, disabled under both pin settings
    for (int k = 0; k < 5; k++) begin
      j = (k > 3) ? 3 : k;
      @(posedge clk_sys_i);
      local_output_resolve_pin_i <= (k == 4);
      slow <= (k == 2);
      send_slot(sst[j], {1'b0, sch[j]}, sfa[j]);
      wait_ready();
      if (sfa[j]) r = '{ent[j][15], {1'b0, ent[j][12:9]}, ent[j][8:0]};
      else r = '{ent[j][15], ent[j][12:8], {1'b0, ent[j][7:0]}};
      b = ent[j][14] ? ent[j][7:0] : {r.local_src, r.stream[2:0], r.channel[3:0]};
      if (!ent[j][14]) `CHK(src_req_o, r, "source request")
      drain(sst[j], b, ent[j][13]);
    end
    `CHK(req_count, 2, "source request count")
    // Shifter holds one, fifo four, the sixth slot stalls; then drain in order
    for (int k = 0; k < 6; k++) cpu_write({2'b10, 4'(k + 8), 9'h005}, {8'h60, 4'(k), 4'(k)});
    for (int k = 0; k < 6; k++) send_slot(4'(k + 8), 9'h005, 1'b0);
    repeat (8) @(negedge clk_sys_i);
    `CHK(slot_ready_o, 1'b0, "full fifo stalls slots")
    for (int k = 0; k < 6; k++) drain(4'(k + 8), {4'(k), 4'(k)}, 1'b1);
    stop_test();
  end
endmodule : tb_local_connection_memory

`default_nettype wire
